// file: rtl/cies_alu.sv
// alu: byte results and zero detect for the decoded subset
`timescale 1ns/1ps
`default_nettype none
module cies_alu (
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_fdat,
    input wire logic [7:0] i_lit,
    input wire logic [2:0] i_sel,
    output logic [7:0] o_res,
    output logic o_zero
);
    // select codes: 0 move, 1 complement, 2 decrement, 3 increment, 4 or file, 5 or literal, 6 clear
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    // wrap through all ones comes free from 8-bit arithmetic
    assign dec_v = i_fdat - 8'h01;
    assign inc_v = i_fdat + 8'h01;
    always_comb begin
        unique case (i_sel)
            3'h0: o_res = i_fdat;
            3'h1: o_res = ~i_fdat;
            3'h2: o_res = dec_v;
            3'h3: o_res = inc_v;
            3'h4: o_res = i_acc | i_fdat;
            3'h5: o_res = i_acc | i_lit;
            default: o_res = 8'h00;
        endcase
    end
    // zero flag source for every updating opcode
    assign o_zero = (o_res == 8'h00);
endmodule
`default_nettype wire

// file: rtl/cies_core.sv
// core execute stage for the instruction subset
`timescale 1ns/1ps
`default_nettype none
module cies_core (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [cies_pkg::CIES_IW-1:0] I_INSTR,
    input wire logic [cies_pkg::CIES_DW-1:0] I_FILE_RDATA,
    input wire logic [1:0] I_STATUS_PAGE,
    input wire logic I_PRESCALER_TO_WDOG,
    output logic [cies_pkg::CIES_PCW-1:0] O_PC,
    output logic [cies_pkg::CIES_FAW-1:0] O_FILE_ADDR,
    output logic O_FILE_WE,
    output logic [cies_pkg::CIES_DW-1:0] O_FILE_WDATA,
    output logic [cies_pkg::CIES_DW-1:0] O_ACC,
    output logic O_ZERO_WE,
    output logic O_ZERO_VAL,
    output logic O_WDOG_CLR,
    output logic O_PRESCALER_CLR,
    output logic O_FLAGS_SET,
    output logic O_FLUSH
);
    import cies_pkg::*;
    cies_state_t state_r;
    cies_state_t state_nxt;
    logic [10:0] pc_r;
    logic [10:0] pc_nxt;
    logic [7:0] acc_r;
    logic clracc;
    logic wdclr;
    logic bytop;
    logic skipop;
    logic zupd;
    logic branch;
    logic orlit;
    logic [2:0] sel;
    logic [7:0] res;
    logic zero;
    logic dest_file;
    logic exec;
    logic skip_hit;

    // opcode classification
    cies_dec u_dec (
        .i_ins(I_INSTR),
        .o_clracc(clracc),
        .o_wdclr(wdclr),
        .o_bytop(bytop),
        .o_skipop(skipop),
        .o_zupd(zupd),
        .o_branch(branch),
        .o_orlit(orlit),
        .o_sel(sel)
    );

    // result datapath
    cies_alu u_alu (
        .i_acc(acc_r),
        .i_fdat(I_FILE_RDATA),
        .i_lit(I_INSTR[CIES_LIT8_MSB:0]),
        .i_sel(sel),
        .o_res(res),
        .o_zero(zero)
    );

    // a flushed word is executed as a no-operation, so nothing may act on it
    assign exec = (state_r == CIES_EXEC);
    assign dest_file = I_INSTR[CIES_DEST_BIT];
    assign O_FILE_ADDR = I_INSTR[CIES_FAW-1+CIES_FA_LSB:CIES_FA_LSB];
    assign O_FILE_WE = exec && bytop && dest_file;
    assign O_FILE_WDATA = res;
    assign O_ZERO_WE = exec && zupd;
    assign O_ZERO_VAL = zero;
    assign O_WDOG_CLR = exec && wdclr;
    assign O_FLAGS_SET = exec && wdclr;
    // prescaler only when it serves the watchdog
    assign O_PRESCALER_CLR = exec && wdclr && I_PRESCALER_TO_WDOG;
    assign skip_hit = exec && skipop && zero;
    assign O_FLUSH = !exec;
    assign O_PC = pc_r;
    assign O_ACC = acc_r;

    // next program counter and flush state
    always_comb begin
        state_nxt = CIES_EXEC;
        pc_nxt = pc_r + CIES_ONE11;
        if (exec && branch) begin
            // literal and page bits, second cycle flushed
            pc_nxt = {I_STATUS_PAGE, I_INSTR[CIES_LIT9_MSB:0]};
            state_nxt = CIES_FLUSH;
        end else if (skip_hit) begin
            state_nxt = CIES_FLUSH;
        end
    end

    // accumulator update: a limitation is that a file write to itself is the caller's job
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            acc_r <= CIES_ACC_RST;
        end else if (exec && (clracc || orlit || (bytop && !dest_file))) begin
            // clear, or literal, or any byte op with accumulator destination
            acc_r <= res;
        end
    end

    // sequencing registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pc_r <= CIES_PC_RST;
            state_r <= CIES_EXEC;
        end else begin
            pc_r <= pc_nxt;
            state_r <= state_nxt;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    // opcode field seen by the checks, kept apart from the decoder
    logic [5:0] op6_w;
    assign op6_w = I_INSTR[11:6];

    AST_CLRACC: assert property (exec && clracc |=> acc_r == 8'h00)
        else $error("accumulator not cleared");

    AST_CLRACC_Z: assert property (exec && clracc |-> O_ZERO_WE && O_ZERO_VAL)
        else $error("clear did not set zero");

    AST_CLRACC_NOF: assert property (exec && clracc |-> !O_FILE_WE)
        else $error("clear wrote a file register");

    AST_WDCLR: assert property (exec && wdclr |-> O_WDOG_CLR && O_FLAGS_SET)
        else $error("watchdog clear missing");

    AST_WD_ACC: assert property (exec && wdclr |=> acc_r == $past(acc_r))
        else $error("watchdog clear changed accumulator");

    AST_WD_NOZ: assert property (exec && wdclr |-> !O_ZERO_WE && !O_FILE_WE)
        else $error("watchdog clear touched zero or file");

    AST_PRESC: assert property (O_PRESCALER_CLR |-> I_PRESCALER_TO_WDOG && wdclr)
        else $error("prescaler cleared while serving timer");

    AST_PRESC_SET: assert property (exec && wdclr && I_PRESCALER_TO_WDOG |-> O_PRESCALER_CLR)
        else $error("prescaler not cleared");

    AST_DEST: assert property (exec && bytop && !dest_file |-> !O_FILE_WE)
        else $error("file written for accumulator destination");

    AST_ACC_DEST: assert property (exec && bytop && !dest_file |=> acc_r == $past(res))
        else $error("accumulator not loaded");

    AST_DEST_FILE: assert property (exec && bytop && dest_file |-> O_FILE_WE && O_FILE_WDATA == res)
        else $error("file destination not written");

    AST_DEST_HOLD: assert property (exec && bytop && dest_file |=> acc_r == $past(acc_r))
        else $error("accumulator changed on file destination");

    AST_COMP: assert property (exec && op6_w == CIES_OP6_COMP |-> O_FILE_WDATA == ~I_FILE_RDATA && O_ZERO_WE)
        else $error("complement wrong");

    AST_DEC: assert property (exec && op6_w == CIES_OP6_DEC |-> O_FILE_WDATA == I_FILE_RDATA - 8'h01 && O_ZERO_WE)
        else $error("decrement wrong");

    AST_DECSZ: assert property (exec && op6_w == CIES_OP6_DECSZ |-> O_FILE_WDATA == I_FILE_RDATA - 8'h01)
        else $error("decrement skip result wrong");

    AST_SKIP_NOZ: assert property (exec && skipop |-> !O_ZERO_WE)
        else $error("skip op touched zero flag");

    AST_DECSZ_FL: assert property (exec && op6_w == CIES_OP6_DECSZ && I_FILE_RDATA == 8'h01 |=> O_FLUSH)
        else $error("decrement skip did not flush");

    AST_DECSZ_NF: assert property (exec && op6_w == CIES_OP6_DECSZ && I_FILE_RDATA != 8'h01 |=> !O_FLUSH)
        else $error("decrement skip flushed on nonzero");

    AST_SKIP: assert property (skip_hit |=> O_FLUSH ##1 !O_FLUSH)
        else $error("skip flush not one cycle");

    AST_BRANCH: assert property (exec && branch |=> O_PC == {$past(I_STATUS_PAGE), $past(I_INSTR[8:0])})
        else $error("branch target wrong");

    AST_BR2: assert property (exec && branch |=> O_FLUSH && !O_FILE_WE && !O_ZERO_WE)
        else $error("branch second cycle not idle");

    // branch alters no flag or file
    AST_BR_FLAG: assert property (exec && branch |-> !O_ZERO_WE && !O_FILE_WE)
        else $error("branch touched status or file");

    AST_BR_ACC: assert property (exec && branch |=> acc_r == $past(acc_r))
        else $error("branch changed accumulator");

    AST_INC: assert property (exec && op6_w == CIES_OP6_INC |-> O_FILE_WDATA == I_FILE_RDATA + 8'h01 && O_ZERO_WE)
        else $error("increment wrong");

    AST_INC_WRAP: assert property (exec && op6_w == CIES_OP6_INC && I_FILE_RDATA == 8'hff |-> O_FILE_WDATA == 8'h00)
        else $error("increment did not wrap");

    // wrap to zero flushes next word
    AST_INCSZ_FL: assert property (exec && op6_w == CIES_OP6_INCSZ && I_FILE_RDATA == 8'hff |=> O_FLUSH)
        else $error("increment skip did not flush");

    AST_INCSZ: assert property (exec && op6_w == CIES_OP6_INCSZ |-> O_FILE_WDATA == I_FILE_RDATA + 8'h01)
        else $error("increment skip result wrong");

    AST_ORL: assert property (exec && orlit |=> acc_r == ($past(acc_r) | $past(I_INSTR[7:0])))
        else $error("or literal result wrong");

    AST_ORL_Z: assert property (exec && orlit |-> O_ZERO_WE && !O_FILE_WE)
        else $error("or literal strobes wrong");

    AST_ORF: assert property (exec && op6_w == CIES_OP6_ORF |-> O_FILE_WDATA == (acc_r | I_FILE_RDATA) && O_ZERO_WE)
        else $error("or file wrong");

    AST_MOV: assert property (exec && op6_w == CIES_OP6_MOVE_REGISTER_OP |-> O_FILE_WDATA == I_FILE_RDATA)
        else $error("move result wrong");

    AST_MOVZ: assert property (exec && bytop && sel == 3'h0 |-> O_ZERO_WE)
        else $error("move did not update zero");

    AST_FA: assert property (O_FILE_WE |-> O_FILE_ADDR == I_INSTR[4:0] && I_INSTR[5])
        else $error("file address or destination field wrong");

    AST_ZERO: assert property (O_ZERO_WE |-> O_ZERO_VAL == (res == 8'h00))
        else $error("zero flag value wrong");

    AST_ZERO_NZ: assert property (O_ZERO_WE && O_FILE_WDATA != 8'h00 |-> !O_ZERO_VAL)
        else $error("zero flag set on nonzero result");

    AST_PC1: assert property (exec && !branch && !skip_hit |=> O_PC == $past(O_PC) + 11'h001 && !O_FLUSH)
        else $error("pc did not advance by one");

    AST_FLUSH_IDLE: assert property (O_FLUSH |-> !O_FILE_WE && !O_ZERO_WE && !O_WDOG_CLR && !O_FLAGS_SET)
        else $error("flushed word had an effect");

    AST_REFUSED: assert property (exec && !bytop && !clracc && !wdclr && !orlit && !branch |=> acc_r == $past(acc_r))
        else $error("unknown opcode changed accumulator");

    // main scenarios reached
    COV_BRANCH: cover property (exec && branch);
    COV_SKIP: cover property (skip_hit);
    COV_WDCLR_PRESC: cover property (O_PRESCALER_CLR);
    COV_FILE_WR: cover property (O_FILE_WE && O_ZERO_WE);
endmodule
`default_nettype wire

// file: rtl/cies_dec.sv
// decoder: opcode classification of the fetched word
`timescale 1ns/1ps
`default_nettype none
module cies_dec (
    input wire logic [11:0] i_ins,
    output logic o_clracc,
    output logic o_wdclr,
    output logic o_bytop,
    output logic o_skipop,
    output logic o_zupd,
    output logic o_branch,
    output logic o_orlit,
    output logic [2:0] o_sel
);
    import cies_pkg::*;
    logic [5:0] op6;
    assign op6 = i_ins[11:6];
    assign o_clracc = (i_ins == CIES_OP_CLRACC);
    assign o_wdclr = (i_ins == CIES_OP_WDCLR);
    assign o_orlit = (i_ins[11:8] == CIES_OP4_ORL);
    assign o_branch = (i_ins[11:9] == CIES_OP3_BRA);
    assign o_skipop = (op6 == CIES_OP6_DECSZ) || (op6 == CIES_OP6_INCSZ);
    assign o_bytop = o_skipop || (op6 == CIES_OP6_COMP) || (op6 == CIES_OP6_DEC) ||
        (op6 == CIES_OP6_INC) || (op6 == CIES_OP6_ORF) || (op6 == CIES_OP6_MOVE_REGISTER_OP);
    // skip forms leave status alone
    // move updates zero, skips do not
    assign o_zupd = o_clracc || o_orlit || (o_bytop && !o_skipop);
    always_comb begin
        if (o_clracc) begin
            o_sel = 3'h6;
        end else if (o_orlit) begin
            o_sel = 3'h5;
        end else if (op6 == CIES_OP6_COMP) begin
            o_sel = 3'h1;
        end else if (op6 == CIES_OP6_DEC || op6 == CIES_OP6_DECSZ) begin
            o_sel = 3'h2;
        end else if (op6 == CIES_OP6_INC || op6 == CIES_OP6_INCSZ) begin
            o_sel = 3'h3;
        end else if (op6 == CIES_OP6_ORF) begin
            o_sel = 3'h4;
        end else begin
            o_sel = 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/cies_pkg.sv
// package: opcodes, field positions, widths and reset values of the execute subset
package cies_pkg;
    localparam int CIES_IW = 12;
    localparam int CIES_DW = 8;
    localparam int CIES_PCW = 11;
    localparam int CIES_FAW = 5;
    // field positions of the byte-oriented, literal and branch forms and the status page
    localparam int CIES_DEST_BIT = 5;
    localparam int CIES_FA_LSB = 0;
    localparam int CIES_LIT8_MSB = 7;
    localparam int CIES_LIT9_MSB = 8;
    localparam int CIES_STAT_PG_LSB = 5;
    // full-word opcodes
    localparam logic [11:0] CIES_OP_CLRACC = 12'h040;
    localparam logic [11:0] CIES_OP_WDCLR = 12'h004;
    localparam logic [11:0] CIES_OP_NOP = 12'h000;
    // byte-oriented opcodes, bits 11:6
    localparam logic [5:0] CIES_OP6_COMP = 6'h09;
    localparam logic [5:0] CIES_OP6_DEC = 6'h03;
    localparam logic [5:0] CIES_OP6_DECSZ = 6'h0b;
    localparam logic [5:0] CIES_OP6_INC = 6'h0a;
    localparam logic [5:0] CIES_OP6_INCSZ = 6'h0f;
    localparam logic [5:0] CIES_OP6_ORF = 6'h04;
    localparam logic [5:0] CIES_OP6_MOVE_REGISTER_OP = 6'h08;
    // literal forms
    localparam logic [3:0] CIES_OP4_ORL = 4'hd;
    localparam logic [2:0] CIES_OP3_BRA = 3'h5;
    // reset values and unit increments
    localparam logic [7:0] CIES_ACC_RST = 8'h00;
    localparam logic [10:0] CIES_PC_RST = 11'h000;
    localparam logic [7:0] CIES_ONE8 = 8'h01;
    localparam logic [10:0] CIES_ONE11 = 11'h001;
    typedef enum logic [1:0] {CIES_EXEC, CIES_FLUSH} cies_state_t;
endpackage

// file: tb/cies_fmem.sv
// file register space model facing the execute core
`timescale 1ns/1ps
`default_nettype none
module cies_fmem (
    input wire logic i_clk,
    input wire logic [4:0] i_addr,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    // bench presets cells directly; unset cells read unknown on purpose
    logic [7:0] mem [0:31];
    assign o_rdata = mem[i_addr];
    // file destination lands at the edge
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule
`default_nettype wire

// file: tb/core_instruction_execute_subset_tb_top.sv
// self-checking bench: instruction sequences against the execute subset core
`timescale 1ns/1ps
`default_nettype none
module core_instruction_execute_subset_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] instr = 12'h000;
    logic [1:0] page = 2'b00;
    logic pto = 1'b0;
    logic [7:0] fdat;
    logic [10:0] pc;
    logic [4:0] fa;
    logic fwe;
    logic [7:0] fwd;
    logic [7:0] acc;
    logic zwe;
    logic zv;
    logic wclr;
    logic pclr;
    logic fset;
    logic flush;
    int num_errors = 0;
    int checked = 0;
    // the nop present at reset release executes first, so counting starts at one
    logic [10:0] epc = 11'h001;
    logic [7:0] eacc = 8'h00;
    logic [7:0] r;
    logic [4:0] a;
    logic [11:0] iw;
    logic [1:0] n_page = 2'b00;
    logic n_pto = 1'b0;
    logic [5:0] bops [5] = '{6'h09, 6'h03, 6'h0a, 6'h04, 6'h08};
    logic [7:0] fv [5] = '{8'h13, 8'h01, 8'hff, 8'h91, 8'h00};
    logic [5:0] sops [3] = '{6'h0f, 6'h0b, 6'h0b};
    logic [7:0] sv [3] = '{8'hff, 8'h05, 8'h01};

    cies_core DUT (.I_CLK(clk), .I_RST(rst), .I_INSTR(instr), .I_FILE_RDATA(fdat), .I_STATUS_PAGE(page),
        .I_PRESCALER_TO_WDOG(pto), .O_PC(pc), .O_FILE_ADDR(fa), .O_FILE_WE(fwe), .O_FILE_WDATA(fwd),
        .O_ACC(acc), .O_ZERO_WE(zwe), .O_ZERO_VAL(zv), .O_WDOG_CLR(wclr), .O_PRESCALER_CLR(pclr),
        .O_FLAGS_SET(fset), .O_FLUSH(flush));
    cies_fmem u_fm (.i_clk(clk), .i_addr(fa), .i_we(fwe), .i_wdata(fwd), .o_rdata(fdat));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // reference byte result, computed apart from the design
    function automatic logic [7:0] calc(input logic [5:0] op, input logic [7:0] f, input logic [7:0] w);
        case (op)
            6'h09: calc = ~f;
            6'h03, 6'h0b: calc = f - 8'h01;
            6'h04: calc = w | f;
            6'h08: calc = f;
            default: calc = f + 8'h01;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // drive one word at the edge, then look once the edge has settled
    task automatic issue(input logic [11:0] ins);
        @(posedge clk);
        instr <= ins;
        page <= n_page;
        pto <= n_pto;
        #2;
        chk("pc", pc, epc);
        epc = epc + 11'h001;
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        chk("pc_rst", pc, 16'h0000);
        chk("acc_rst", acc, 16'h0000);
        rst <= 1'b0;
        issue(12'hd35);
        chk("orl_z", {zwe, zv}, 16'h0002);
        issue(12'h040);
        chk("orl_acc", acc, 16'h0035);
        chk("clr_z", {zwe, zv}, 16'h0003);
        // watchdog clear with the prescaler attached, then detached
        for (int p = 1; p >= 0; p--) begin
            n_pto = p[0];
            issue(12'h004);
            chk("clr_acc", acc, 16'h0000);
            chk("wdog", {wclr, fset, pclr, zwe}, {2'b11, p[0], 1'b0});
        end
        // each routed byte op to both destinations
        for (int i = 0; i < 10; i++) begin
            a = 5'(i + 8);
            u_fm.mem[a] = fv[i/2];
            issue({bops[i/2], i[0], a});
            r = calc(bops[i/2], fv[i/2], eacc);
            chk("acc", acc, eacc);
            chk("fa_we", {fa, fwe}, {a, i[0]});
            chk("zero", {zwe, zv}, {1'b1, r == 8'h00});
            if (i[0]) chk("res", fwd, r);
            if (!i[0]) eacc = r;
        end
        // an opcode outside the subset only steps the counter
        issue(12'h1c8);
        chk("refused", {zwe, fwe}, 16'h0000);
        // skip ops: a zero result turns the next word into a nop
        for (int i = 0; i < 3; i++) begin
            a = 5'(i + 20);
            u_fm.mem[a] = sv[i];
            issue({sops[i], ~i[0], a});
            r = calc(sops[i], sv[i], eacc);
            chk("skz", {zwe, fwe}, {1'b0, ~i[0]});
            if (i[0]) eacc = r;
            issue(12'hd80);
            chk("flush", {flush, zwe}, {r == 8'h00, r != 8'h00});
            if (r != 8'h00) eacc = eacc | 8'h80;
            issue(12'h000);
            chk("sk_acc", acc, eacc);
        end
        // branch on two pages; the following word must be dropped
        for (int i = 0; i < 2; i++) begin
            n_page = 2'(i + 1);
            iw = i[0] ? 12'hba5 : 12'haff;
            issue(iw);
            epc = {n_page, iw[8:0]};
            issue(12'h040);
            chk("br_fl", {flush, zwe}, 16'h0002);
            issue(12'h000);
            chk("br_acc", acc, eacc);
        end
        close_out();
    end

    // the whole sequence needs well under a microsecond
    initial begin
        #20000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
